/* hdl/hbp_pkg.sv */
// Constants and types shared by the quad channel host bus port
package hbp_pkg;
	// =====================================================
	// Widths
	// =====================================================
	localparam int HBP_DATA_W = 8;      // Data bus width
	localparam int HBP_ADDR_W = 3;      // Register address width
	localparam int HBP_CHAN_N = 4;      // Number of channels
	localparam int HBP_CHAN_W = 2;      // Channel index width

	// =====================================================
	// Pin positions and encodings
	// =====================================================
	localparam int HBP_CS_A = 0;        // Channel A select bit
	localparam int HBP_CS_B = 1;        // Channel B select bit, address 3 in bus6800 mode
	localparam int HBP_CS_C = 2;        // Channel C select bit, address 4 in bus6800 mode
	localparam int HBP_CS_D = 3;        // Channel D select bit
	localparam logic HBP_MODE_STROBE = 1'h1; // Mode pin level for strobe bus
	localparam logic HBP_DIR_READ = 1'h1;    // Direction pin level for read in bus6800 mode

	// =====================================================
	// Reset values
	// =====================================================
	localparam logic [HBP_DATA_W-1:0] HBP_DATA_RST = 8'h00; // Read data latch
	localparam logic [HBP_ADDR_W-1:0] HBP_ADDR_RST = 3'h0;  // Latched address
	localparam logic [HBP_CHAN_W-1:0] HBP_CHAN_RST = 2'h0;  // Latched channel
	localparam logic [HBP_CHAN_N-1:0] HBP_IRQ_OE_N_RST = 4'hF; // All irq pins released
	localparam logic [HBP_CHAN_N-1:0] HBP_IRQ_OUT_RST = 4'h0;  // Irq pin levels

	// =====================================================
	// Transaction states
	// =====================================================
	typedef enum logic [1:0]
	{
		HBP_IDLE = 2'b00,
		HBP_READ = 2'b01,
		HBP_WRITE = 2'b10
	} hbp_state_t;
endpackage

/* hdl/hbp_pin_sample.sv */
// Pin sampler with previous value and edge flags
`timescale 1ns/100ps
module hbp_pin_sample
	import hbp_pkg::*;
#(
	parameter int W = 1,              // Pin group width
	parameter logic [W-1:0] IDLE = '1 // Level held during reset
)
(
	input wire logic i_clk,           // System clock
	input wire logic i_rst_n,         // Synchronised reset, active low
	input wire logic i_ce,            // Clock enable
	input wire logic [W-1:0] i_pin,   // Raw pin levels
	output logic [W-1:0] o_now,       // Sampled level
	output logic [W-1:0] o_prev,      // Level one sample earlier
	output logic [W-1:0] o_fall,      // High to low seen
	output logic [W-1:0] o_rise       // Low to high seen
);
	logic [W-1:0] next_now; // Next sample
	logic [W-1:0] next_prev; // Next previous sample

	// =====================================================
	// Sampling
	// =====================================================
	// Pins are synchronous to the clock, so one stage is enough
	always_comb
	begin
		next_now = i_pin;
		next_prev = o_now;
	end

	// Idle level is a parameter, so the async reset loads only a constant
	// and no false edge follows reset while the pins rest at idle
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_now <= IDLE;
			o_prev <= IDLE;
		end
		else if (i_ce)
		begin
			o_now <= next_now;
			o_prev <= next_prev;
		end
	end

	assign o_fall = o_prev & ~o_now;
	assign o_rise = ~o_prev & o_now;
endmodule

/* hdl/hbp_host_port.sv */
// Host bus port of a four channel serial device, strobe and bus6800 styles
`timescale 1ns/100ps
module hbp_host_port
	import hbp_pkg::*;
(
	input wire logic i_clk,                        // System clock, 50 MHz
	input wire logic i_rst_n,                      // Async reset, active low
	input wire logic i_ce,                         // Clock enable, freezes state when low
	input wire logic i_mode_strobe,                // 1 strobe bus, 0 bus6800
	input wire logic i_host_read_strobe_n,         // Read strobe, active low
	input wire logic i_host_write_strobe_n,        // Write strobe, or direction
	input wire logic i_chan_a_select_n,            // Select A, or chip select
	input wire logic i_chan_b_select_n,            // Select B, or address 3
	input wire logic i_chan_c_select_n,            // Select C, or address 4
	input wire logic i_chan_d_select_n,            // Select D, unused in bus6800
	input wire logic [HBP_ADDR_W-1:0] i_addr,      // Register address lines
	input wire logic [HBP_DATA_W-1:0] i_data,      // Data bus input
	output logic [HBP_DATA_W-1:0] o_data,          // Data bus output
	output logic o_data_oe_n,                      // Data bus enable, low drives
	output logic o_chan_a_irq_out,                 // Irq pin A level
	output logic o_chan_a_irq_oe_n,                // Irq pin A enable, low drives
	output logic o_chan_b_irq_out,                 // Irq pin B level
	output logic o_chan_b_irq_oe_n,                // Irq pin B enable, low drives
	output logic o_chan_c_irq_out,                 // Irq pin C level
	output logic o_chan_c_irq_oe_n,                // Irq pin C enable, low drives
	output logic o_chan_d_irq_out,                 // Irq pin D level
	output logic o_chan_d_irq_oe_n,                // Irq pin D enable, low drives
	output logic o_combined_tx_ready_n,            // AND of channel tx ready
	output logic o_combined_rx_ready_n,            // AND of channel rx ready
	input wire logic [HBP_CHAN_N-1:0] i_irq_pend,  // Channel irq pending, high
	input wire logic [HBP_CHAN_N-1:0] i_irq_output_enable_bit, // Channel irq enable
	input wire logic [HBP_CHAN_N-1:0] i_tx_ready_n, // Channel tx ready, active low
	input wire logic [HBP_CHAN_N-1:0] i_rx_ready_n, // Channel rx ready, active low
	input wire logic [HBP_DATA_W-1:0] i_reg_rdata, // Read data of addressed register
	output logic o_reg_rd,                         // Register read pulse
	output logic o_reg_wr,                         // Register write pulse
	output logic [HBP_CHAN_W-1:0] o_reg_chan,      // Target channel
	output logic [HBP_ADDR_W-1:0] o_reg_addr,      // Target register
	output logic [HBP_DATA_W-1:0] o_reg_wdata      // Write data
);
	// =====================================================
	// Reset release
	// =====================================================
	logic [1:0] rst_pipe; // Two stage release
	logic rst_sync_n; // Design reset

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_sync_n = rst_pipe[1];

	// =====================================================
	// Pin sampling
	// =====================================================
	logic rd_fall, rd_rise; // Read strobe
	logic wr_now, wr_fall, wr_rise; // Write strobe or direction
	logic [HBP_CHAN_N-1:0] cs_now, cs_fall, cs_rise; // Chip selects
	logic [HBP_ADDR_W-1:0] addr_now; // Address
	logic [HBP_DATA_W-1:0] data_prev; // Data bus in, one sample back
	logic [HBP_CHAN_N-1:0] cs_pins; // Select pins gathered

	assign cs_pins = {i_chan_d_select_n, i_chan_c_select_n, i_chan_b_select_n, i_chan_a_select_n};

	hbp_pin_sample #(.W(1), .IDLE(1'b1)) u_rd (.i_clk(i_clk), .i_rst_n(rst_sync_n),
		.i_ce(i_ce), .i_pin(i_host_read_strobe_n), .o_now(), .o_prev(),
		.o_fall(rd_fall), .o_rise(rd_rise));
	hbp_pin_sample #(.W(1), .IDLE(1'b1)) u_wr (.i_clk(i_clk), .i_rst_n(rst_sync_n),
		.i_ce(i_ce), .i_pin(i_host_write_strobe_n), .o_now(wr_now), .o_prev(),
		.o_fall(wr_fall), .o_rise(wr_rise));
	hbp_pin_sample #(.W(HBP_CHAN_N), .IDLE(4'hF)) u_cs (.i_clk(i_clk), .i_rst_n(rst_sync_n),
		.i_ce(i_ce), .i_pin(cs_pins), .o_now(cs_now), .o_prev(),
		.o_fall(cs_fall), .o_rise(cs_rise));
	hbp_pin_sample #(.W(HBP_ADDR_W), .IDLE(3'h7)) u_addr (.i_clk(i_clk), .i_rst_n(rst_sync_n),
		.i_ce(i_ce), .i_pin(i_addr), .o_now(addr_now), .o_prev(),
		.o_fall(), .o_rise());
	hbp_pin_sample #(.W(HBP_DATA_W), .IDLE(8'hFF)) u_data (.i_clk(i_clk), .i_rst_n(rst_sync_n),
		.i_ce(i_ce), .i_pin(i_data), .o_now(), .o_prev(data_prev),
		.o_fall(), .o_rise());

	// =====================================================
	// Channel select decode
	// =====================================================
	logic any_cs; // Some channel selected in strobe mode
	logic [HBP_CHAN_W-1:0] strobe_chan; // Lowest selected channel
	logic [HBP_CHAN_W-1:0] m68_chan; // Channel from address 4:3

	// Several selects low at once is a host fault; lowest channel wins
	always_comb
	begin
		any_cs = ~&cs_now;
		strobe_chan = 2'h0;
		if (!cs_now[HBP_CS_A])
			strobe_chan = 2'h0;
		else if (!cs_now[HBP_CS_B])
			strobe_chan = 2'h1;
		else if (!cs_now[HBP_CS_C])
			strobe_chan = 2'h2;
		else
			strobe_chan = 2'h3;
		m68_chan = {cs_now[HBP_CS_C], cs_now[HBP_CS_B]};
	end

	// =====================================================
	// Transaction engine
	// =====================================================
	hbp_state_t state, next_state; // Bus cycle state
	logic next_rd, next_wr; // Register strobes
	logic [HBP_CHAN_W-1:0] next_chan; // Latched channel
	logic [HBP_ADDR_W-1:0] next_addr; // Latched address
	logic [HBP_DATA_W-1:0] next_wdata; // Write data
	logic [HBP_DATA_W-1:0] next_dout; // Read data to bus
	logic end_rd, end_wr; // End of the host cycle

	// Read and channel D select pins are not looked at in bus6800 mode
	always_comb
	begin
		next_state = state;
		next_rd = 1'b0;
		next_wr = 1'b0;
		next_chan = o_reg_chan;
		next_addr = o_reg_addr;
		next_wdata = o_reg_wdata;
		next_dout = o_data;
		end_rd = (i_mode_strobe == HBP_MODE_STROBE) ? rd_rise : cs_rise[HBP_CS_A];
		end_wr = (i_mode_strobe == HBP_MODE_STROBE) ? wr_rise : cs_rise[HBP_CS_A];
		case (state)
			HBP_IDLE:
			begin
				if (i_mode_strobe == HBP_MODE_STROBE)
				begin
					// Read strobe wins if both strobes fall together
					if (rd_fall && any_cs)
					begin
						next_state = HBP_READ;
						next_rd = 1'b1;
						next_chan = strobe_chan;
						next_addr = addr_now;
					end
					else if (wr_fall && any_cs)
					begin
						next_state = HBP_WRITE;
						next_chan = strobe_chan;
						next_addr = addr_now;
					end
				end
				else if (cs_fall[HBP_CS_A])
				begin
					next_chan = m68_chan;
					next_addr = addr_now;
					if (wr_now == HBP_DIR_READ)
					begin
						next_state = HBP_READ;
						next_rd = 1'b1;
					end
					else
						next_state = HBP_WRITE;
				end
			end
			HBP_READ:
			begin
				// Follow the channel output until the cycle closes
				next_dout = i_reg_rdata;
				if (end_rd)
					next_state = HBP_IDLE;
			end
			HBP_WRITE:
			begin
				if (end_wr)
				begin
					// Byte seen while the strobe was still low
					next_state = HBP_IDLE;
					next_wr = 1'b1;
					next_wdata = data_prev;
				end
			end
			default:
				next_state = HBP_IDLE;
		endcase
	end

	// Data bus enable follows the next state so it turns with the state
	always_ff @(posedge i_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			state <= HBP_IDLE;
			o_reg_rd <= 1'b0;
			o_reg_wr <= 1'b0;
			o_reg_chan <= HBP_CHAN_RST;
			o_reg_addr <= HBP_ADDR_RST;
			o_reg_wdata <= HBP_DATA_RST;
			o_data <= HBP_DATA_RST;
			o_data_oe_n <= 1'b1;
		end
		else if (i_ce)
		begin
			state <= next_state;
			o_reg_rd <= next_rd;
			o_reg_wr <= next_wr;
			o_reg_chan <= next_chan;
			o_reg_addr <= next_addr;
			o_reg_wdata <= next_wdata;
			o_data <= next_dout;
			o_data_oe_n <= (next_state != HBP_READ);
		end
	end

	// =====================================================
	// Interrupt pins and ready status
	// =====================================================
	logic [HBP_CHAN_N-1:0] irq_out, next_irq_out; // Irq pin levels
	logic [HBP_CHAN_N-1:0] irq_oe_n, next_irq_oe_n; // Irq pin enables
	logic next_tx_n, next_rx_n; // Combined ready

	always_comb
	begin
		next_tx_n = &i_tx_ready_n;
		next_rx_n = &i_rx_ready_n;
		if (i_mode_strobe == HBP_MODE_STROBE)
		begin
			// Pin floats unless its channel enables it
			next_irq_out = i_irq_pend;
			next_irq_oe_n = ~i_irq_output_enable_bit;
		end
		else
		begin
			// Open drain: only ever pulls low, needs a board pull-up
			next_irq_out = HBP_IRQ_OUT_RST;
			next_irq_oe_n = 4'h0;
			next_irq_oe_n[HBP_CS_A] = ~|(i_irq_pend & i_irq_output_enable_bit);
		end
	end

	always_ff @(posedge i_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			irq_out <= HBP_IRQ_OUT_RST;
			irq_oe_n <= HBP_IRQ_OE_N_RST;
			o_combined_tx_ready_n <= 1'b1;
			o_combined_rx_ready_n <= 1'b1;
		end
		else if (i_ce)
		begin
			irq_out <= next_irq_out;
			irq_oe_n <= next_irq_oe_n;
			o_combined_tx_ready_n <= next_tx_n;
			o_combined_rx_ready_n <= next_rx_n;
		end
	end

	assign o_chan_a_irq_out = irq_out[HBP_CS_A];
	assign o_chan_b_irq_out = irq_out[HBP_CS_B];
	assign o_chan_c_irq_out = irq_out[HBP_CS_C];
	assign o_chan_d_irq_out = irq_out[HBP_CS_D];
	assign o_chan_a_irq_oe_n = irq_oe_n[HBP_CS_A];
	assign o_chan_b_irq_oe_n = irq_oe_n[HBP_CS_B];
	assign o_chan_c_irq_oe_n = irq_oe_n[HBP_CS_C];
	assign o_chan_d_irq_oe_n = irq_oe_n[HBP_CS_D];

	// =====================================================
	// Checks
	// =====================================================
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_sync_n);

	chk_read_start_drive: assert property (
		i_ce && state == HBP_IDLE && i_mode_strobe && rd_fall && any_cs
		|=> o_reg_rd && !o_data_oe_n)
		else $error("read strobe did not start a read");
	chk_write_at_rise: assert property (
		i_ce && state == HBP_WRITE && i_mode_strobe && wr_rise
		|=> o_reg_wr && o_reg_wdata == $past(data_prev) && o_data_oe_n)
		else $error("write strobe rise did not store data");
	chk_dir_read: assert property (
		i_ce && state == HBP_IDLE && !i_mode_strobe && cs_fall[0] && wr_now
		|=> o_reg_rd ##1 !o_data_oe_n)
		else $error("direction high did not read");
	chk_no_select_idle: assert property (
		i_ce && state == HBP_IDLE && !i_mode_strobe && cs_now[0]
		|=> state == HBP_IDLE && !o_reg_rd)
		else $error("access without chip select");
	chk_chan_decode: assert property (
		i_ce && state == HBP_IDLE && !i_mode_strobe && cs_fall[0]
		|=> o_reg_chan == {$past(cs_now[2]), $past(cs_now[1])})
		else $error("bus6800 channel decode wrong");
	chk_strobe_chan_b: assert property (
		i_ce && state == HBP_IDLE && i_mode_strobe && rd_fall && cs_now == 4'hD
		|=> o_reg_chan == 2'h1 && o_reg_addr == $past(addr_now))
		else $error("strobe channel select wrong");
	chk_irq_enable: assert property (
		i_ce && i_mode_strobe |=> o_chan_b_irq_oe_n == !$past(i_irq_output_enable_bit[1]))
		else $error("irq pin enable wrong");
	chk_shared_irq: assert property (
		i_ce && !i_mode_strobe && |(i_irq_pend & i_irq_output_enable_bit)
		|=> !o_chan_a_irq_oe_n && !o_chan_a_irq_out)
		else $error("shared irq not pulled low");
	chk_unused_irq_low: assert property (
		i_ce && !i_mode_strobe |=> !o_chan_c_irq_out && !o_chan_c_irq_oe_n && !o_chan_d_irq_out)
		else $error("unused irq pins not low");
	chk_tx_and: assert property (
		i_ce |=> o_combined_tx_ready_n == &$past(i_tx_ready_n))
		else $error("combined tx ready wrong");
	chk_rx_and: assert property (
		i_ce |=> o_combined_rx_ready_n == &$past(i_rx_ready_n))
		else $error("combined rx ready wrong");
	chk_bus_quiet_write: assert property (
		o_reg_wr |-> o_data_oe_n)
		else $error("data bus driven during write");

	cov_strobe_read: cover property (o_reg_rd && i_mode_strobe);
	cov_strobe_write: cover property (o_reg_wr && i_mode_strobe);
	cov_m68_write: cover property (o_reg_wr && !i_mode_strobe);
	cov_shared_irq: cover property (!i_mode_strobe && !o_chan_a_irq_oe_n);
endmodule

/* bench/hbp_host_model.sv */
// Host processor model that drives the parallel bus pins of the port
`timescale 1ns/100ps
module hbp_host_model
	import hbp_pkg::*;
(
	input wire logic i_clk,                          // System clock
	input wire logic i_mode_strobe,                  // Bus style, 1 strobe
	input wire logic [HBP_DATA_W-1:0] i_dev_data,    // Device data out
	input wire logic i_dev_oe_n,                     // Device drive enable, low drives
	output logic o_rd_n,                             // Read strobe
	output logic o_wr_n,                             // Write strobe or direction
	output logic [HBP_CHAN_N-1:0] o_sel_n,           // Selects, bit0 channel A
	output logic [HBP_ADDR_W-1:0] o_addr,            // Register address
	output wire logic [HBP_DATA_W-1:0] o_bus         // Resolved data bus
);
	// =====================================
	// Data bus
	// =====================================
	logic drv;                      // Host drives the bus
	logic [HBP_DATA_W-1:0] wdat;    // Byte the host drives
	logic [HBP_DATA_W-1:0] last = 8'h00; // Bus level one cycle back, known from the start
	// Undriven bus toggles every cycle, so a stale byte never matches by luck
	assign o_bus = !i_dev_oe_n ? i_dev_data : (drv ? wdat : ~last);
	always @(negedge i_clk)
		last <= o_bus;

	// Idle levels from time zero; read strobe and select D stay high in bus6800
	initial
	begin
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_sel_n = 4'hF;
		o_addr = 3'h0;
		drv = 1'b0;
		wdat = 8'h00;
	end

	// =====================================
	// Bus cycles, pins move only at the falling edge
	// =====================================
	// Channel choice: one select per channel, or chip select plus address
	task automatic sel(input logic [1:0] ch);
		if (i_mode_strobe)
			o_sel_n = ~(4'h1 << ch);
		else
			o_sel_n = {1'b1, ch[1], ch[0], 1'b0};
	endtask

	// Read: strobe low well past the data latency, host latches before the rise
	task automatic rd(input logic [1:0] ch, input logic [2:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		sel(ch);
		if (i_mode_strobe)
			o_rd_n = 1'b0;
		else
			o_wr_n = HBP_DIR_READ;
		repeat (5) @(negedge i_clk);
		d = o_bus;
		o_rd_n = 1'b1;
		o_sel_n = 4'hF;
		repeat (3) @(negedge i_clk);
	endtask

	// Write: data held one cycle past the strobe rise as hold time
	task automatic wr(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		sel(ch);
		wdat = d;
		drv = 1'b1;
		o_wr_n = 1'b0;
		repeat (4) @(negedge i_clk);
		o_wr_n = 1'b1;
		o_sel_n = 4'hF;
		@(negedge i_clk);
		drv = 1'b0;
		repeat (3) @(negedge i_clk);
	endtask
endmodule

/* bench/tb_quad_uart_host_bus_port.sv */
// Self-checking testbench of the host bus port in both bus styles
`timescale 1ns/100ps
module tb_quad_uart_host_bus_port
	import hbp_pkg::*;
;
	// =====================================
	// Signals
	// =====================================
	logic clk, rst_n, mode, ce;       // Clock, reset, bus style, clock enable
	logic [3:0] pend, en, txr, rxr;   // Channel side inputs
	logic rd_n, wr_n;                 // Host strobes
	logic [3:0] sel_n;                // Host selects
	logic [2:0] addr;                 // Host address
	logic [7:0] bus, dout, rdata;     // Data bus, device out, register data
	logic doe_n, ra, rb, rc, rd, ea, eb, ec, ed, txo, rxo; // Device pins
	logic prd, pwr;                   // Register pulses
	logic [1:0] rchan;                // Register channel
	logic [2:0] raddr;                // Register address
	logic [7:0] rwdat;                // Register write data
	int bad_count, compares, cycles, n_rd, n_wr; // Counters
	logic [12:0] wr_word;             // Channel, address, data at write pulse
	logic wr_busy;                    // Host write under way

	// Register file stand-in: byte encodes channel and address
	assign rdata = {1'b1, rchan, 2'b01, raddr};

	hbp_host_port DUT (
		.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_mode_strobe(mode),
		.i_host_read_strobe_n(rd_n), .i_host_write_strobe_n(wr_n),
		.i_chan_a_select_n(sel_n[0]), .i_chan_b_select_n(sel_n[1]),
		.i_chan_c_select_n(sel_n[2]), .i_chan_d_select_n(sel_n[3]),
		.i_addr(addr), .i_data(bus), .o_data(dout), .o_data_oe_n(doe_n),
		.o_chan_a_irq_out(ra), .o_chan_a_irq_oe_n(ea), .o_chan_b_irq_out(rb),
		.o_chan_b_irq_oe_n(eb), .o_chan_c_irq_out(rc), .o_chan_c_irq_oe_n(ec),
		.o_chan_d_irq_out(rd), .o_chan_d_irq_oe_n(ed),
		.o_combined_tx_ready_n(txo), .o_combined_rx_ready_n(rxo),
		.i_irq_pend(pend), .i_irq_output_enable_bit(en), .i_tx_ready_n(txr),
		.i_rx_ready_n(rxr), .i_reg_rdata(rdata), .o_reg_rd(prd), .o_reg_wr(pwr),
		.o_reg_chan(rchan), .o_reg_addr(raddr), .o_reg_wdata(rwdat)
	);

	hbp_host_model host (
		.i_clk(clk), .i_mode_strobe(mode), .i_dev_data(dout), .i_dev_oe_n(doe_n),
		.o_rd_n(rd_n), .o_wr_n(wr_n), .o_sel_n(sel_n), .o_addr(addr), .o_bus(bus)
	);

	// =====================================
	// Clock, monitor and closing
	// =====================================
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// One comparison of any result, mismatch reported at once
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic close_out();
		$display("Comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Pulses stand one cycle, so each falling edge sees a pulse exactly once
	always @(negedge clk)
	begin
		cycles++;
		if (prd === 1'b1)
			n_rd++;
		if (pwr === 1'b1)
		begin
			n_wr++;
			wr_word = {rchan, raddr, rwdat};
		end
		if (wr_busy)
			chk("bus idle on write", 16'h1, {15'h0, doe_n});
		if (cycles == 3000)
		begin
			bad_count++;
			close_out();
		end
	end

	// =====================================
	// Scenarios
	// =====================================
	// Reads and writes on every channel at both address boundaries
	task automatic t_bus();
		logic [7:0] d, w;
		for (int c = 0; c < 4; c++)
		begin
			for (int k = 0; k < 2; k++)
			begin
				n_rd = 0;
				n_wr = 0;
				host.rd(2'(c), 3'(7 * k), d);
				chk("read data", {8'h0, 1'b1, 2'(c), 2'b01, 3'(7 * k)}, {8'h0, d});
				chk("read pulses", 16'h0100, {8'(n_rd), 8'(n_wr)});
				chk("read release", 16'h1, {15'h0, doe_n});
				w = 8'hA5 ^ 8'(c * 16 + k);
				wr_busy = 1'b1;
				host.wr(2'(c), 3'(7 * k), w);
				wr_busy = 1'b0;
				chk("write pulses", 16'h0101, {8'(n_rd), 8'(n_wr)});
				chk("write word", {3'h0, 2'(c), 3'(7 * k), w}, {3'h0, wr_word});
			end
		end
	endtask

	// Every pending pattern, enable set to pending XOR 6, checked one edge after it is set
	task automatic t_irq();
		for (int v = 0; v < 16; v++)
		begin
			pend = 4'(v);
			en = 4'(v) ^ 4'h6;
			@(negedge clk);
			if (mode)
				chk("irq strobe", {8'h0, pend, ~en}, {8'h0, rd, rc, rb, ra, ed, ec, eb, ea});
			else
				chk("irq shared", {15'h0, ~|(pend & en)},
					{8'h0, rd, rc, rb, ra, ed, ec, eb, ea});
		end
	endtask

	// Combined ready flags over all channel patterns
	task automatic t_ready();
		for (int v = 0; v < 16; v++)
		begin
			txr = 4'(v);
			rxr = ~4'(v);
			@(negedge clk);
			chk("ready", {14'h0, &txr, &rxr}, {14'h0, txo, rxo});
		end
	endtask

	// Clock enable low must hold the registered ready output, high lets it follow
	task automatic t_freeze();
		txr = 4'h0;
		@(negedge clk);
		ce = 1'b0;
		txr = 4'hF;
		repeat (2) @(negedge clk);
		chk("frozen ready", 16'h0, {15'h0, txo});
		ce = 1'b1;
		@(negedge clk);
		chk("thawed ready", 16'h1, {15'h0, txo});
	endtask

	// =====================================
	// Main sequence
	// =====================================
	initial
	begin
		rst_n = 1'b0;
		ce = 1'b1;
		mode = HBP_MODE_STROBE;
		pend = 4'h0;
		en = 4'h0;
		txr = 4'hF;
		rxr = 4'hF;
		wr_busy = 1'b0;
		bad_count = 0;
		compares = 0;
		cycles = 0;
		repeat (3) @(negedge clk);
		chk("reset levels", 16'hFE00, {doe_n, ea, eb, ec, ed, txo, rxo, prd, pwr, ra, 6'h0});
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (5) @(negedge clk);
		t_bus();
		t_irq();
		t_ready();
		t_freeze();
		mode = ~HBP_MODE_STROBE;
		repeat (5) @(negedge clk);
		t_bus();
		t_irq();
		close_out();
	end
endmodule
